// [design/lctrf_defines.svh]
// Purpose: offsets, field positions, reset values and wrap counts
// Assumes: byte addresses on a 32-bit register bus
// Notes: definitions only
`ifndef LCTRF_DEFINES_SVH
`define LCTRF_DEFINES_SVH

`define LCTRF_ADDR_CYCLE_TIME 12'h0F0
`define LCTRF_ADDR_FILT_SET 12'h100
`define LCTRF_ADDR_FILT_CLR 12'h104
`define LCTRF_ADDR_CTRL 12'h110

`define LCTRF_FILT_RESET 32'h00000000
`define LCTRF_CTRL_RESET 3'h0
`define LCTRF_TIME_RESET 32'h00000000

`define LCTRF_CTRL_MASTER 0
`define LCTRF_CTRL_FREE_RUN 1
`define LCTRF_CTRL_EXT_MODE 2

`define LCTRF_SEC_MSB 31
`define LCTRF_SEC_LSB 25
`define LCTRF_CYC_MSB 24
`define LCTRF_CYC_LSB 12
`define LCTRF_OFS_MSB 11
`define LCTRF_OFS_LSB 0

`define LCTRF_OFS_LAST 12'hBFF
`define LCTRF_CYC_LAST 13'h1F3F

`define LCTRF_ALL_BUS_BIT 31
`define LCTRF_NODE_BASE 6'h20
`define LCTRF_NODE_BCAST 6'h3F
`define LCTRF_BUS_LOCAL 10'h3FF

`define LCTRF_RESP_OKAY 2'h0
`define LCTRF_RESP_SLVERR 2'h2

`endif

// [design/lctrf_pkg.sv]
// Purpose: types shared by the cycle timer and request filter block
// Assumes: nothing
// Notes: numbers live in lctrf_defines.svh
`default_nettype none
package lctrf_pkg;
  typedef enum logic [1:0] {
    W_IDLE = 2'h0,
    W_ADDR = 2'h1,
    W_RESP = 2'h3,
    W_DATA = 2'h2
  } lctrf_wr_e;

  typedef struct packed {
    logic [6:0] seconds_field;
    logic [12:0] cycle_number_field;
    logic [11:0] tick_offset_field;
  } lctrf_time_s;

  typedef struct packed {
    lctrf_wr_e wst;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] filter;
    logic [2:0] ctrl;
    logic [1:0] ref_sync;
    logic [1:0] ext_sync;
    logic ref_last;
    logic ext_last;
    logic ref_tick;
    logic ext_tick;
    logic sw_load;
    logic [31:0] sw_data;
    logic cs_load;
    logic [31:0] cs_data;
    logic tx_valid;
    logic [31:0] tx_data;
    logic req_done;
    logic req_upper;
    logic req_accept;
  } lctrf_top_s;
endpackage
`default_nettype wire

// [design/lctrf_timer_if.sv]
// Purpose: carrier between the register side and the cycle counter
// Assumes: single clock
// Notes: ctl drives requests, tmr returns the running value
`default_nettype none
interface lctrf_timer_if;
  logic ref_tick;
  logic ext_tick;
  logic ext_mode;
  logic run;
  logic sw_load;
  logic [31:0] sw_data;
  logic cs_load;
  logic [31:0] cs_data;
  lctrf_pkg::lctrf_time_s value;
  modport ctl(
    output ref_tick, ext_tick, ext_mode, run,
    output sw_load, sw_data, cs_load, cs_data,
    input value
  );
  modport tmr(
    input ref_tick, ext_tick, ext_mode, run,
    input sw_load, sw_data, cs_load, cs_data,
    output value
  );
endinterface
`default_nettype wire

// [design/lctrf_timer.sv]
// Purpose: seconds / cycle / offset counter
// Assumes: ticks are one-cycle pulses on the core clock
// Notes: software load beats a received load, which beats counting
`default_nettype none
module lctrf_timer (
  input wire logic clk,
  input wire logic rst,
  lctrf_timer_if.tmr tif
);
  import lctrf_pkg::*;
  `include "lctrf_defines.svh"

  lctrf_time_s cur;
  lctrf_time_s next_cur;

  function automatic lctrf_time_s bump_cycle(input lctrf_time_s t);
    lctrf_time_s r;
    r = t;
    r.tick_offset_field = 12'h000;
    if (t.cycle_number_field == `LCTRF_CYC_LAST) begin
      r.cycle_number_field = 13'h0000;
      r.seconds_field = t.seconds_field + 7'h01;
    end else begin
      r.cycle_number_field = t.cycle_number_field + 13'h0001;
    end
    return r;
  endfunction

  always_comb begin
    next_cur = cur;
    if (tif.sw_load) begin
      next_cur = tif.sw_data;
    end else if (tif.cs_load) begin
      next_cur = tif.cs_data;
    end else if (tif.ext_mode) begin
      if (tif.ext_tick) begin
        next_cur = bump_cycle(cur);
      end else if (tif.ref_tick && tif.run) begin
        next_cur.tick_offset_field = cur.tick_offset_field + 12'h001;
      end
    end else if (tif.ref_tick && tif.run) begin
      if (cur.tick_offset_field == `LCTRF_OFS_LAST) begin
        next_cur = bump_cycle(cur);
      end else begin
        next_cur.tick_offset_field = cur.tick_offset_field + 12'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= `LCTRF_TIME_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign tif.value = cur;
endmodule
`default_nettype wire

// [design/lctrf_top.sv]
// Purpose: isochronous cycle timer and upper request filter registers
// Assumes: AXI4-Lite slave on CORE_CLK, 125 MHz, sync reset RST
// Notes: reference and 8 kHz clocks arrive on pins and are synchronised
`default_nettype none

module lctrf_top (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic REF_CLK_PIN,
  input wire logic EXT_CYCLE_CLK_PIN,
  input wire logic RX_CS_VALID,
  input wire logic [31:0] RX_CS_DATA,
  input wire logic TX_CS_REQ,
  output logic TX_CS_VALID,
  output logic [31:0] TX_CS_DATA,
  input wire logic REQ_VALID,
  input wire logic [9:0] REQ_SRC_BUS,
  input wire logic [5:0] REQ_SRC_NODE,
  input wire logic [9:0] LOCAL_BUS,
  output logic REQ_DONE,
  output logic REQ_UPPER,
  output logic REQ_ACCEPT
);
  import lctrf_pkg::*;
  `include "lctrf_defines.svh"

  lctrf_top_s s;
  lctrf_top_s next_s;
  lctrf_timer_if tif();

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic have_addr;
  logic have_data;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;
  logic [31:0] cur_time;
  logic src_local;
  logic [4:0] node_idx;
  logic [11:0] rd_addr;

  // byte strobes to bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return m;
  endfunction

  // word-aligned byte address
  function automatic logic [11:0] word_addr(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'h0};
    return w;
  endfunction

  // byte-lane merge of a new word into an old one
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [31:0] mask
  );
    logic [31:0] w;
    w = (old_word & ~mask) | (new_word & mask);
    return w;
  endfunction

  // mapped register check
  function automatic logic is_mapped(input logic [11:0] a);
    logic hit;
    hit = (a == `LCTRF_ADDR_CYCLE_TIME) ||
          (a == `LCTRF_ADDR_FILT_SET) ||
          (a == `LCTRF_ADDR_FILT_CLR) ||
          (a == `LCTRF_ADDR_CTRL);
    return hit;
  endfunction

  // read data selection
  function automatic logic [31:0] read_mux(
    input logic [11:0] a,
    input logic [31:0] t,
    input logic [31:0] f,
    input logic [2:0] c
  );
    logic [31:0] d;
    d = 32'h00000000;
    case (a)
      `LCTRF_ADDR_CYCLE_TIME: begin
        d = t;
      end
      `LCTRF_ADDR_FILT_SET: begin
        d = f;
      end
      `LCTRF_ADDR_FILT_CLR: begin
        d = f;
      end
      `LCTRF_ADDR_CTRL: begin
        d = {29'h00000000, c};
      end
      default: begin
        d = 32'h00000000;
      end
    endcase
    return d;
  endfunction

  lctrf_timer u_timer (
    .clk(CORE_CLK),
    .rst(RST),
    .tif(tif)
  );

  assign cur_time = tif.value;
  assign tif.ref_tick = s.ref_tick;
  assign tif.ext_tick = s.ext_tick;
  assign tif.ext_mode = s.ctrl[`LCTRF_CTRL_EXT_MODE];
  assign tif.sw_load = s.sw_load;
  assign tif.sw_data = s.sw_data;
  assign tif.cs_load = s.cs_load;
  assign tif.cs_data = s.cs_data;

  // master always counts reference ticks, others only when free running
  assign tif.run = s.ctrl[`LCTRF_CTRL_MASTER] |
                   s.ctrl[`LCTRF_CTRL_FREE_RUN];

  assign aw_fire = AWVALID && s.awready;
  assign w_fire = WVALID && s.wready;
  assign ar_fire = ARVALID && s.arready;
  assign have_addr = aw_fire || (s.wst == W_ADDR);
  assign have_data = w_fire || (s.wst == W_DATA);
  assign wr_addr = aw_fire ? word_addr(AWADDR) : s.awaddr;
  // reads decode the word that holds the byte address
  assign rd_addr = word_addr(ARADDR);
  assign wr_data = w_fire ? WDATA : s.wdata;
  assign wr_mask = strb_mask(w_fire ? WSTRB : s.wstrb);

  // bus number all ones also means local
  assign src_local = (REQ_SRC_BUS == LOCAL_BUS) ||
                     (REQ_SRC_BUS == `LCTRF_BUS_LOCAL);
  // filter bit n serves node n plus 32
  assign node_idx = 5'(REQ_SRC_NODE - `LCTRF_NODE_BASE);

  always_comb begin
    next_s = s;
    next_s.sw_load = 1'h0;
    next_s.cs_load = 1'h0;
    next_s.tx_valid = 1'h0;
    next_s.req_done = 1'h0;

    // pin synchronisers and rising-edge pulses
    next_s.ref_sync = {s.ref_sync[0], REF_CLK_PIN};
    next_s.ext_sync = {s.ext_sync[0], EXT_CYCLE_CLK_PIN};
    next_s.ref_last = s.ref_sync[1];
    next_s.ext_last = s.ext_sync[1];
    // one tick per reference clock rising edge
    next_s.ref_tick = s.ref_sync[1] && !s.ref_last;
    // one tick per external cycle clock rising edge
    next_s.ext_tick = s.ext_sync[1] && !s.ext_last;

    // load from received cycle start when not master
    if (RX_CS_VALID && !s.ctrl[`LCTRF_CTRL_MASTER]) begin
      next_s.cs_load = 1'h1;
      next_s.cs_data = RX_CS_DATA;
    end

    if (TX_CS_REQ && s.ctrl[`LCTRF_CTRL_MASTER]) begin
      next_s.tx_valid = 1'h1;
      next_s.tx_data = cur_time;
    end

    // check each request bound for filtered contexts
    if (REQ_VALID) begin
      next_s.req_done = 1'h1;
      if (!src_local) begin
        // remote buses only with the all-buses bit
        next_s.req_upper = 1'h1;
        next_s.req_accept = s.filter[`LCTRF_ALL_BUS_BIT];
      end else if (REQ_SRC_NODE >= `LCTRF_NODE_BASE) begin
        next_s.req_upper = 1'h1;
        if (REQ_SRC_NODE == `LCTRF_NODE_BCAST) begin
          next_s.req_accept = 1'h0;
        end else begin
          // clear bit refuses acknowledge and queueing
          next_s.req_accept = s.filter[node_idx];
        end
      end else begin
        next_s.req_upper = 1'h0;
        next_s.req_accept = 1'h0;
      end
    end

    // write address and data, either order
    if (aw_fire) begin
      next_s.awaddr = word_addr(AWADDR);
      next_s.awready = 1'h0;
    end
    if (w_fire) begin
      next_s.wdata = WDATA;
      next_s.wstrb = WSTRB;
      next_s.wready = 1'h0;
    end

    case (s.wst)
      W_IDLE: begin
        if (have_addr && have_data) begin
          next_s.wst = W_RESP;
        end else if (aw_fire) begin
          next_s.wst = W_ADDR;
        end else if (w_fire) begin
          next_s.wst = W_DATA;
        end
      end
      W_ADDR: begin
        if (w_fire) begin
          next_s.wst = W_RESP;
        end
      end
      W_DATA: begin
        if (aw_fire) begin
          next_s.wst = W_RESP;
        end
      end
      W_RESP: begin
        if (BREADY) begin
          next_s.bvalid = 1'h0;
          next_s.awready = 1'h1;
          next_s.wready = 1'h1;
          next_s.wst = W_IDLE;
        end
      end
      default: begin
        next_s.wst = W_IDLE;
      end
    endcase

    // register update as the write completes
    if (s.wst != W_RESP && have_addr && have_data) begin
      next_s.bvalid = 1'h1;
      next_s.bresp = is_mapped(wr_addr) ? `LCTRF_RESP_OKAY
                                        : `LCTRF_RESP_SLVERR;
      case (wr_addr)
        `LCTRF_ADDR_CYCLE_TIME: begin
          next_s.sw_load = 1'h1;
          next_s.sw_data = lane_merge(cur_time, wr_data, wr_mask);
        end
        `LCTRF_ADDR_FILT_SET: begin
          next_s.filter = lane_merge(s.filter, s.filter | wr_data, wr_mask);
        end
        `LCTRF_ADDR_FILT_CLR: begin
          next_s.filter = lane_merge(s.filter, s.filter & ~wr_data,
                                     wr_mask);
        end
        `LCTRF_ADDR_CTRL: begin
          // control needs its low byte lane
          if (wr_mask[0]) begin
            next_s.ctrl = wr_data[2:0];
          end
        end
        default: begin
          next_s.filter = s.filter;
        end
      endcase
    end

    // read channel
    if (ar_fire) begin
      next_s.arready = 1'h0;
      next_s.rvalid = 1'h1;
      next_s.rdata = read_mux(rd_addr, cur_time, s.filter, s.ctrl);
      next_s.rresp = is_mapped(rd_addr) ?
                     `LCTRF_RESP_OKAY : `LCTRF_RESP_SLVERR;
    end else if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'h0;
      next_s.arready = 1'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s <= '0;
      s.wst <= W_IDLE;
      s.awready <= 1'h1;
      s.wready <= 1'h1;
      s.arready <= 1'h1;
      s.filter <= `LCTRF_FILT_RESET;
      s.ctrl <= `LCTRF_CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign AWREADY = s.awready;
  assign WREADY = s.wready;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = s.arready;
  assign RVALID = s.rvalid;
  assign RDATA = s.rdata;
  assign RRESP = s.rresp;
  assign TX_CS_VALID = s.tx_valid;
  assign TX_CS_DATA = s.tx_data;
  assign REQ_DONE = s.req_done;
  assign REQ_UPPER = s.req_upper;
  assign REQ_ACCEPT = s.req_accept;
endmodule
`default_nettype wire

// [verification/lctrf_top_asserts.sv]
// Purpose: port checks of timer stamp and filter
// Assumes: sees top ports only
// Notes: bound to lctrf_top
`default_nettype none
module lctrf_top_asserts (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic AWREADY,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic TX_CS_REQ,
  input wire logic TX_CS_VALID,
  input wire logic REQ_VALID,
  input wire logic [9:0] REQ_SRC_BUS,
  input wire logic [5:0] REQ_SRC_NODE,
  input wire logic [9:0] LOCAL_BUS,
  input wire logic REQ_DONE,
  input wire logic REQ_UPPER,
  input wire logic REQ_ACCEPT
);
  logic loc;
  assign loc = REQ_SRC_BUS == LOCAL_BUS || REQ_SRC_BUS == 10'h3FF;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  a_stamp_cause: assert property (
    TX_CS_VALID |-> $past(TX_CS_REQ)) else $error("stray stamp");
  a_req_answer: assert property (
    REQ_VALID |=> REQ_DONE) else $error("no decision");
  a_done_cause: assert property (
    REQ_DONE |-> $past(REQ_VALID)) else $error("stray decision");
  a_local_low: assert property (
    REQ_VALID && loc && !REQ_SRC_NODE[5] |=> !REQ_UPPER && !REQ_ACCEPT)
    else $error("low node taken");
  a_node_top: assert property (
    REQ_VALID && loc && &REQ_SRC_NODE |=> REQ_UPPER && !REQ_ACCEPT)
    else $error("node 63 taken");
  a_remote_upper: assert property (
    REQ_VALID && !loc |=> REQ_UPPER) else $error("remote not upper");
  a_write_answer: assert property (
    $rose(BVALID) |-> !AWREADY && !WREADY) else $error("early response");
  a_read_cause: assert property (
    $rose(RVALID) |-> $past(ARVALID)) else $error("stray read data");
  a_resp_done: assert property (
    BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
    else $error("write response not closed");
  a_read_done: assert property (
    RVALID && RREADY |=> !RVALID && ARREADY)
    else $error("read response not closed");
endmodule
bind lctrf_top lctrf_top_asserts u_lctrf_top_asserts (.CORE_CLK, .RST,
  .AWREADY, .WREADY, .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID,
  .RREADY, .TX_CS_REQ, .TX_CS_VALID,
  .REQ_VALID, .REQ_SRC_BUS, .REQ_SRC_NODE, .LOCAL_BUS, .REQ_DONE,
  .REQ_UPPER, .REQ_ACCEPT);
`default_nettype wire

// [verification/lctrf_link_model.sv]
// Purpose: link side: reference clock, 8 kHz tick, cycle starts
// Assumes: bench calls its tasks
// Notes: idle data shows the inverse of the last word
`default_nettype none
module lctrf_link_model (
  input wire logic clk,
  input wire logic ref_en,
  output logic ref_clk,
  output logic ext_clk,
  output logic cs_valid,
  output logic [31:0] cs_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ref_clk = 1'h0;
    ext_clk = 1'h0;
    cs_valid = 1'h0;
    cs_data = 32'h0;
  end
  always #20.345 ref_clk = ref_en ? ~ref_clk : 1'h0;
  task automatic send_cs(input logic [31:0] d);
    @(posedge clk);
    cs_valid <= 1'h1;
    cs_data <= d;
    @(posedge clk);
    cs_valid <= 1'h0;
    cs_data <= ~d;
  endtask
  task automatic ext_pulse();
    @(posedge clk);
    ext_clk <= 1'h1;
    repeat (25) @(posedge clk);
    ext_clk <= 1'h0;
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Purpose: self-checking bench of lctrf_top
// Assumes: AXI4-Lite master tasks, link model
// Notes: row loop for filter decisions
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK = 1'h0, RST = 1'h1, ref_en = 1'h0;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
  logic ARVALID = 1'h0, RREADY = 1'h0, TX_CS_REQ = 1'h0, REQ_VALID = 1'h0;
  logic [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
  logic [31:0] WDATA = 32'h0, RDATA, TX_CS_DATA, cs_d;
  logic [3:0] WSTRB = 4'hF;
  logic [9:0] REQ_SRC_BUS = 10'h0, LOCAL_BUS = 10'h005;
  logic [5:0] REQ_SRC_NODE = 6'h0;
  logic [1:0] BRESP, RRESP;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_CS_VALID;
  logic REQ_DONE, REQ_UPPER, REQ_ACCEPT, ref_pin, ext_pin, cs_v;
  int failures = 0, samples_checked = 0, cyc = 0;
  localparam logic [17:0] ROWS [7] = '{{10'h005, 6'h3E, 2'h3},
    {10'h005, 6'h33, 2'h2}, {10'h005, 6'h20, 2'h3}, {10'h3FF, 6'h3E, 2'h3},
    {10'h005, 6'h3F, 2'h2}, {10'h005, 6'h05, 2'h0}, {10'h001, 6'h00, 2'h3}};
  lctrf_top u_lctrf_top (.CORE_CLK, .RST, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
    .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .REF_CLK_PIN(ref_pin), .EXT_CYCLE_CLK_PIN(ext_pin), .RX_CS_VALID(cs_v),
    .RX_CS_DATA(cs_d), .TX_CS_REQ, .TX_CS_VALID, .TX_CS_DATA, .REQ_VALID,
    .REQ_SRC_BUS, .REQ_SRC_NODE, .LOCAL_BUS, .REQ_DONE, .REQ_UPPER,
    .REQ_ACCEPT);
  lctrf_link_model u_lctrf_link_model (.clk(CORE_CLK), .ref_en,
    .ref_clk(ref_pin), .ext_clk(ext_pin), .cs_valid(cs_v), .cs_data(cs_d));
  always #4 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checked %0d failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    do begin
      @(posedge CORE_CLK);
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
    end while (!BVALID);
    BREADY <= 1'h0;
    chk({30'h0, BRESP}, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] r);
    @(posedge CORE_CLK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do begin
      @(posedge CORE_CLK);
      if (ARREADY) ARVALID <= 1'h0;
    end while (!RVALID);
    RREADY <= 1'h0;
    chk(RDATA, e);
    chk({30'h0, RRESP}, {30'h0, r});
  endtask
  task automatic req(input logic [17:0] w);
    @(posedge CORE_CLK);
    {REQ_SRC_BUS, REQ_SRC_NODE} <= w[17:2];
    REQ_VALID <= 1'h1;
    @(posedge CORE_CLK);
    REQ_VALID <= 1'h0;
    #1;
    chk({29'h0, REQ_DONE, REQ_UPPER, REQ_ACCEPT},
      {29'h0, 1'h1, w[1:0]});
  endtask
  initial begin
    repeat (6) @(posedge CORE_CLK);
    RST <= 1'h0;
    rd(12'h100, 32'h0, 2'h0);
    req({10'h001, 6'h00, 2'h2});
    wr(12'h100, 32'hC008_0001);
    wr(12'h104, 32'h0008_0000);
    rd(12'h104, 32'hC000_0001, 2'h0);
    for (int i = 0; i < 7; i++) req(ROWS[i]);
    WSTRB <= 4'h1;
    wr(12'h100, 32'hFFFF_FFFF);
    WSTRB <= 4'hF;
    rd(12'h100, 32'hC000_00FF, 2'h0);
    wr(12'h0F0, 32'hFFF3_FBFF);
    rd(12'h0F0, 32'hFFF3_FBFF, 2'h0);
    wr(12'h110, 32'h2);
    ref_en = 1'h1;
    repeat (3) @(posedge ref_pin);
    ref_en = 1'h0;
    repeat (10) @(posedge CORE_CLK);
    rd(12'h0F0, 32'h0000_0002, 2'h0);
    wr(12'h110, 32'h0);
    u_lctrf_link_model.send_cs(32'h1357_0246);
    rd(12'h0F0, 32'h1357_0246, 2'h0);
    wr(12'h110, 32'h1);
    u_lctrf_link_model.send_cs(32'h0000_0123);
    @(posedge CORE_CLK);
    TX_CS_REQ <= 1'h1;
    @(posedge CORE_CLK);
    TX_CS_REQ <= 1'h0;
    #1;
    chk({31'h0, TX_CS_VALID}, 32'h1);
    chk(TX_CS_DATA, 32'h1357_0246);
    wr(12'h110, 32'h4);
    WSTRB <= 4'h0;
    wr(12'h110, 32'h1);
    WSTRB <= 4'hF;
    rd(12'h110, 32'h4, 2'h0);
    wr(12'h0F0, 32'h0000_5100);
    u_lctrf_link_model.ext_pulse();
    repeat (10) @(posedge CORE_CLK);
    rd(12'h0F0, 32'h0000_6000, 2'h0);
    rd(12'h200, 32'h0, 2'h2);
    @(posedge CORE_CLK);
    RST <= 1'h1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'h0;
    rd(12'h100, 32'h0, 2'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
